// [hw/ufc_core.sv]
// UART FIFO control, enhanced features, divisor latch and break logic
//
// How it works
// RULE1 - Receive threshold code 00/01/10/11 selects 8/16/56/60 characters.
// RULE2 - Transmit threshold code 00/01/10/11 selects 8/16/32/56 free spaces.
// RULE3 - Transmit FIFO reset empties FIFO, keeps shift register, then self-clears.
// RULE4 - Receive FIFO reset empties FIFO, keeps shift register, then self-clears.
// RULE5 - FIFO disabled: one character each way, other bits ignored, trigger one.
// RULE6 - FIFO enabled: both FIFOs hold up to 64 characters.
// RULE7 - Transmit threshold changes only while the unlock bit is set.
// RULE8 - FIFO control is reached at offset 2 only with divisor select clear.
// RULE9 - Enhanced feature register at offset 2 when line control is BF, select low.
// RULE10 - Enhanced bit 7 enables automatic CTS transmit gating.
// RULE11 - Enhanced bit 6 enables automatic RTS driven by receive level.
// RULE12 - Special match without stop compare is stored and raises special flag.
// RULE13 - Special match with stop compare acts as flow control, not stored.
// RULE14 - Unlock bit gates enhanced writes and permits sleep mode.
// RULE15 - Upper flow-select bits choose which stop/resume pairs transmit.
// RULE16 - Lower flow-select bits choose which pair the receiver compares.
// RULE17 - Codes 1011 and 0111 accept either resume and either stop character.
// RULE18 - Codes 1111 and 0011 require both characters in sequence.
// RULE19 - Line control bit 7 maps low offsets onto the divisor latch.
// RULE20 - Line control bit 6 forces the transmit pin low for break.
// RULE21 - Line control resets to 1D.
// RULE22 - Divisor high byte reached only with select set and not BF; the code also reaches it at BF while specialFuncSel is high.
// RULE23 - Stop-caused flag clears on resume; special-caused flag clears on read.
// RULE24 - Triggers assert when occupancy or free space reaches the level.
// RULE25 - FIFO reset bits self-clear one cycle after the write.
module ufc_core
   import ufc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Host register port
   input  wire logic [2:0] hostAddr,
   input  wire logic       hostWr,
   input  wire logic       hostRd,
   input  wire logic [7:0] hostWrData,
   output      logic [7:0] hostRdData,
   input  wire logic       specialFuncSel,
   // Receive shift register side
   input  wire ufc_char_t  rxIn,
   // Transmit shift register side
   output      logic       txValid,
   output      logic [7:0] txByte,
   input  wire logic       txTake,
   input  wire logic       txLineIn,
   // Pins
   output      logic       txPin,
   output      logic       rtsN,
   input  wire logic       ctsN,
   // Status and configuration out
   output      logic       rxTrigger,
   output      logic       txTrigger,
   output      logic [15:0] divisor,
   output      logic [1:0] txFlowSelect,
   output      logic       sleepAllowed
);

   typedef struct packed {
      logic [7:0]       lineCtl;
      logic [7:0]       enhCtl;
      logic             fifoEn;
      logic [1:0]       rxThr;
      logic [1:0]       txThr;
      logic [1:0]       rstPend;
      logic [7:0]       divLow;
      logic [7:0]       divHigh;
      logic [3:0][7:0]  flowChar;
      logic [63:0][7:0] rxMem;
      logic [63:0][7:0] txMem;
      logic [5:0]       rxWr;
      logic [5:0]       rxRd;
      logic [6:0]       rxCnt;
      logic [5:0]       txWr;
      logic [5:0]       txRd;
      logic [6:0]       txCnt;
      logic             swHalt;
      logic             seqStop;
      logic             seqRes;
      logic             flagStop;
      logic             flagSpec;
      logic [1:0]       ctsSync;
      logic [7:0]       rdData;
      logic             txValid;
      logic [7:0]       txByte;
      logic             txPin;
      logic             rtsN;
      logic             rxTrig;
      logic             txTrig;
   } ufc_state_t;

   ufc_state_t state_reg;
   ufc_state_t state_next;
   logic       specStore;
   logic       flowHit;
   logic       enhBank;

   // Receive trigger level; one character while FIFOs are off
   function automatic logic [6:0] rxLevel(input logic [1:0] code, input logic en);
      logic [6:0] lvl;
      case (code)
         2'h0:    lvl = LVL_8;
         2'h1:    lvl = LVL_16;
         2'h2:    lvl = LVL_56;
         default: lvl = LVL_60;
      endcase
      return en ? lvl : DEPTH_OFF;
   endfunction

   // Transmit trigger level in free spaces
   function automatic logic [6:0] txLevel(input logic [1:0] code, input logic en);
      logic [6:0] lvl;
      case (code)
         2'h0:    lvl = LVL_8;
         2'h1:    lvl = LVL_16;
         2'h2:    lvl = LVL_32;
         default: lvl = LVL_56;
      endcase
      return en ? lvl : DEPTH_OFF;
   endfunction

   // Next-state logic
   always_comb begin
      logic [7:0] b;
      logic [6:0] cap;
      logic       either;
      logic       seqMode;
      logic       cmpStop2;
      logic       isS1;
      logic       isS2;
      logic       isR1;
      logic       isR2;
      logic       stopDone;
      logic       resDone;
      logic       consumed;
      logic       rxPush;
      logic       rxPop;
      logic       txPush;
      logic       txPop;
      b         = rxIn.data;
      state_next = state_reg;
      specStore = 1'b0;
      flowHit   = 1'b0;
      stopDone  = 1'b0;
      resDone   = 1'b0;
      consumed  = 1'b0;
      rxPush    = 1'b0;
      rxPop     = 1'b0;
      txPush    = 1'b0;
      txPop     = 1'b0;
      // RULE5 RULE6 capacity by mode
      cap       = state_reg.fifoEn ? DEPTH_ON : DEPTH_OFF;
      // RULE9 enhanced bank key
      enhBank   = (state_reg.lineCtl == ENH_KEY) && !specialFuncSel;
      state_next.ctsSync = {state_reg.ctsSync[0], ctsN};
      state_next.rstPend = 2'h0;

      // RULE17 RULE18 receive comparison style
      either   = (state_reg.enhCtl[1:0] == FS_BOTH) &&
                 (state_reg.enhCtl[3:2] == FS_FIRST || state_reg.enhCtl[3:2] == FS_SECOND);
      seqMode  = (state_reg.enhCtl[1:0] == FS_BOTH) && !either;
      cmpStop2 = state_reg.enhCtl[1:0] == FS_SECOND || state_reg.enhCtl[1:0] == FS_BOTH;
      isR1     = b == state_reg.flowChar[0];
      isR2     = b == state_reg.flowChar[1];
      isS1     = b == state_reg.flowChar[2];
      isS2     = b == state_reg.flowChar[3];

      // Host register writes
      if (hostWr) begin
         if (enhBank) begin
            case (hostAddr)
               // RULE9 enhanced feature register
               OFS_FIFO:  state_next.enhCtl = hostWrData;
               OFS_LINE:  state_next.lineCtl = hostWrData;
               OFS_RES1:  state_next.flowChar[0] = hostWrData;
               OFS_RES2:  state_next.flowChar[1] = hostWrData;
               OFS_STOP1: state_next.flowChar[2] = hostWrData;
               OFS_STOP2: state_next.flowChar[3] = hostWrData;
               default:   ;
            endcase
         end else if (state_reg.lineCtl[LC_DIVSEL]) begin
            // RULE19 RULE22 divisor latch on low offsets
            case (hostAddr)
               OFS_DIV_LOW:  state_next.divLow = hostWrData;
               OFS_DIV_HIGH: state_next.divHigh = hostWrData;
               OFS_LINE:     state_next.lineCtl = hostWrData;
               default:      ;
            endcase
         end else begin
            case (hostAddr)
               OFS_DATA: txPush = state_reg.txCnt < cap;
               // RULE8 fifo control write
               OFS_FIFO: begin
                  state_next.fifoEn = hostWrData[FC_EN];
                  // RULE5 other bits ignored when disabled
                  if (hostWrData[FC_EN]) begin
                     state_next.rxThr   = hostWrData[7:6];
                     state_next.rstPend = hostWrData[FC_TXRST:FC_RXRST];
                     // RULE7 RULE14 unlock gates the transmit threshold
                     if (state_reg.enhCtl[EF_UNLOCK]) begin
                        state_next.txThr = hostWrData[5:4];
                     end
                  end
               end
               OFS_LINE: state_next.lineCtl = hostWrData;
               default:  ;
            endcase
         end
      end

      // Host reads: data pops the receive FIFO, identification clears special flag
      state_next.rdData = ZERO_BYTE;
      if (hostRd) begin
         if (enhBank) begin
            case (hostAddr)
               OFS_FIFO:  state_next.rdData = state_reg.enhCtl;
               OFS_LINE:  state_next.rdData = state_reg.lineCtl;
               OFS_RES1:  state_next.rdData = state_reg.flowChar[0];
               OFS_RES2:  state_next.rdData = state_reg.flowChar[1];
               OFS_STOP1: state_next.rdData = state_reg.flowChar[2];
               OFS_STOP2: state_next.rdData = state_reg.flowChar[3];
               default:   ;
            endcase
         end else if (state_reg.lineCtl[LC_DIVSEL]) begin
            case (hostAddr)
               OFS_DIV_LOW:  state_next.rdData = state_reg.divLow;
               OFS_DIV_HIGH: state_next.rdData = state_reg.divHigh;
               OFS_LINE:     state_next.rdData = state_reg.lineCtl;
               default:      ;
            endcase
         end else begin
            case (hostAddr)
               OFS_DATA: begin
                  rxPop = state_reg.rxCnt != 7'h00;
                  state_next.rdData = state_reg.rxMem[state_reg.rxRd];
               end
               OFS_FIFO: begin
                  state_next.rdData = {state_reg.fifoEn, state_reg.fifoEn, 1'b0,
                     state_reg.flagStop | state_reg.flagSpec, 3'h0,
                     !(state_reg.flagStop | state_reg.flagSpec)};
                  // RULE23 read clears special-caused flag
                  state_next.flagSpec = 1'b0;
               end
               OFS_LINE: state_next.rdData = state_reg.lineCtl;
               default:  ;
            endcase
         end
      end

      // Received character: flow control comparison and special detection
      if (rxIn.valid) begin
         case (state_reg.enhCtl[1:0])
            // RULE16 single-pair comparison
            FS_FIRST: begin
               stopDone = isS1;
               resDone  = isR1;
            end
            FS_SECOND: begin
               stopDone = isS2;
               resDone  = isR2;
            end
            FS_BOTH: begin
               if (either) begin
                  // RULE17 either character counts
                  stopDone = isS1 | isS2;
                  resDone  = isR1 | isR2;
               end else begin
                  // RULE18 both characters in sequence
                  stopDone = state_reg.seqStop && isS2;
                  resDone  = state_reg.seqRes && isR2;
                  state_next.seqStop = isS1;
                  state_next.seqRes  = isR1;
                  consumed = isS1 | isR1;
               end
            end
            default: ;
         endcase
         consumed = consumed | stopDone | resDone;
         flowHit  = consumed;
         if (stopDone) begin
            state_next.swHalt   = 1'b1;
            state_next.flagStop = 1'b1;
         end
         if (resDone) begin
            state_next.swHalt = 1'b0;
            // RULE23 resume clears stop-caused flag
            state_next.flagStop = 1'b0;
         end
         if (state_reg.enhCtl[EF_SPEC] && isS2) begin
            if (cmpStop2 && consumed) begin
               // RULE13 flow action plus both interrupts
               state_next.flagStop = !resDone;
               state_next.flagSpec = 1'b1;
            end else begin
               // RULE12 stored with special flag
               specStore = 1'b1;
               state_next.flagSpec = 1'b1;
            end
         end
         rxPush = !consumed && (state_reg.rxCnt - {6'h0, rxPop}) < cap;
      end
      if (seqMode == 1'b0 && state_reg.enhCtl[1:0] != FS_BOTH) begin
         state_next.seqStop = 1'b0;
         state_next.seqRes  = 1'b0;
      end

      // Transmit pop by the shift register
      txPop = txTake && state_reg.txValid && state_reg.txCnt != 7'h00;

      // Receive FIFO storage
      if (rxPush) begin
         state_next.rxMem[state_reg.rxWr] = b;
         state_next.rxWr = state_reg.rxWr + 6'h1;
      end
      if (rxPop) begin
         state_next.rxRd = state_reg.rxRd + 6'h1;
      end
      state_next.rxCnt = state_reg.rxCnt + {6'h0, rxPush} - {6'h0, rxPop};
      // Transmit FIFO storage
      if (txPush) begin
         state_next.txMem[state_reg.txWr] = hostWrData;
         state_next.txWr = state_reg.txWr + 6'h1;
      end
      if (txPop) begin
         state_next.txRd = state_reg.txRd + 6'h1;
      end
      state_next.txCnt = state_reg.txCnt + {6'h0, txPush} - {6'h0, txPop};

      // RULE4 RULE25 receive reset wins over traffic, shift register untouched
      if (state_reg.rstPend[0]) begin
         state_next.rxWr  = 6'h0;
         state_next.rxRd  = 6'h0;
         state_next.rxCnt = 7'h00;
      end
      // RULE3 RULE25 transmit reset wins over traffic
      if (state_reg.rstPend[1]) begin
         state_next.txWr  = 6'h0;
         state_next.txRd  = 6'h0;
         state_next.txCnt = 7'h00;
      end

      // RULE10 automatic CTS gating of the transmitter
      state_next.txValid = state_next.txCnt != 7'h00 && !state_next.swHalt &&
                           !(state_reg.enhCtl[EF_ACTS] && state_reg.ctsSync[1]);
      state_next.txByte  = state_next.txMem[state_next.txRd];
      // RULE20 break forces the pin low
      state_next.txPin   = state_reg.lineCtl[LC_BREAK] ? 1'b0 : txLineIn;
      // RULE11 automatic RTS from receive level
      state_next.rtsN    = state_reg.enhCtl[EF_ARTS] &&
                           state_reg.rxCnt >= rxLevel(state_reg.rxThr, state_reg.fifoEn);
      // RULE1 RULE2 RULE24 trigger flags
      state_next.rxTrig  = state_reg.rxCnt >= rxLevel(state_reg.rxThr, state_reg.fifoEn);
      state_next.txTrig  = (cap - state_reg.txCnt) >=
                           txLevel(state_reg.txThr, state_reg.fifoEn);
   end

   // State register with synchronous reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= '0;
         // RULE21 line control reset value
         state_reg.lineCtl <= LINE_RESET;
         state_reg.txPin   <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state register
   assign hostRdData   = state_reg.rdData;
   assign txValid      = state_reg.txValid;
   assign txByte       = state_reg.txByte;
   assign txPin        = state_reg.txPin;
   assign rtsN         = state_reg.rtsN;
   assign rxTrigger    = state_reg.rxTrig;
   assign txTrigger    = state_reg.txTrig;
   assign divisor      = {state_reg.divHigh, state_reg.divLow};
   // RULE15 transmit flow-pair selection
   assign txFlowSelect = state_reg.enhCtl[3:2];
   // RULE14 sleep permitted by unlock bit
   assign sleepAllowed = state_reg.enhCtl[EF_UNLOCK];

   // Checks
   chk_line_reset: assert property (@(posedge clk_sys) rst |=> state_reg.lineCtl == LINE_RESET)
      else $error("line control reset value wrong"); // RULE21
   chk_break_pin: assert property (@(posedge clk_sys) disable iff (rst)
      state_reg.lineCtl[LC_BREAK] |=> !txPin)
      else $error("break did not force pin low"); // RULE20
   chk_txrst_empty: assert property (@(posedge clk_sys) disable iff (rst)
      hostWr && !enhBank && !state_reg.lineCtl[LC_DIVSEL] && hostAddr == OFS_FIFO &&
      hostWrData[FC_EN] && hostWrData[FC_TXRST] |=> ##1 state_reg.txCnt == 7'h00)
      else $error("transmit FIFO not emptied"); // RULE3
   chk_rxrst_empty: assert property (@(posedge clk_sys) disable iff (rst)
      hostWr && !enhBank && !state_reg.lineCtl[LC_DIVSEL] && hostAddr == OFS_FIFO &&
      hostWrData[FC_EN] && hostWrData[FC_RXRST] |=> ##1 state_reg.rxCnt == 7'h00)
      else $error("receive FIFO not emptied"); // RULE4
   chk_single_depth: assert property (@(posedge clk_sys) disable iff (rst)
      !state_reg.fifoEn && state_reg.rxCnt <= DEPTH_OFF |=> state_reg.rxCnt <= DEPTH_OFF)
      else $error("non-FIFO mode held more than one"); // RULE5
   chk_full_depth: assert property (@(posedge clk_sys) disable iff (rst)
      state_reg.rxCnt <= DEPTH_ON && state_reg.txCnt <= DEPTH_ON)
      else $error("FIFO count above 64"); // RULE6
   chk_txthr_lock: assert property (@(posedge clk_sys) disable iff (rst)
      !state_reg.enhCtl[EF_UNLOCK] |=> $stable(state_reg.txThr))
      else $error("transmit threshold changed while locked"); // RULE7
   chk_cts_gate: assert property (@(posedge clk_sys) disable iff (rst)
      state_reg.enhCtl[EF_ACTS] && state_reg.ctsSync[1] |=> !txValid)
      else $error("transmit not halted by CTS"); // RULE10
   chk_rts_level: assert property (@(posedge clk_sys) disable iff (rst)
      state_reg.enhCtl[EF_ARTS] && state_reg.rxCnt >= rxLevel(state_reg.rxThr,
      state_reg.fifoEn) |=> rtsN)
      else $error("RTS not deasserted at level"); // RULE11
   chk_special_store: assert property (@(posedge clk_sys) disable iff (rst)
      specStore && !state_reg.rstPend[0] && state_reg.rxCnt < DEPTH_OFF |=>
      state_reg.flagSpec && state_reg.rxCnt == $past(state_reg.rxCnt) + 7'h1)
      else $error("special character not stored"); // RULE12
   chk_flow_nostore: assert property (@(posedge clk_sys) disable iff (rst)
      flowHit && !hostRd && !state_reg.rstPend[0] |=> $stable(state_reg.rxCnt))
      else $error("flow character entered FIFO"); // RULE13
   cov_rx_trigger: cover property (@(posedge clk_sys) disable iff (rst) rxTrigger);
   cov_sw_halt: cover property (@(posedge clk_sys) disable iff (rst) state_reg.swHalt);
   cov_special: cover property (@(posedge clk_sys) disable iff (rst) specStore);
endmodule

// [pkg/ufc_pkg.sv]
// Constants and carrier types for the UART FIFO and flow-control block
package ufc_pkg;
   // Register offsets on the host port
   localparam logic [2:0] OFS_DATA     = 3'h0;
   localparam logic [2:0] OFS_DIV_LOW  = 3'h0;
   localparam logic [2:0] OFS_DIV_HIGH = 3'h1;
   localparam logic [2:0] OFS_FIFO     = 3'h2;
   localparam logic [2:0] OFS_LINE     = 3'h3;
   localparam logic [2:0] OFS_RES1     = 3'h4;
   localparam logic [2:0] OFS_RES2     = 3'h5;
   localparam logic [2:0] OFS_STOP1    = 3'h6;
   localparam logic [2:0] OFS_STOP2    = 3'h7;
   // Reset values and keys
   localparam logic [7:0] LINE_RESET   = 8'h1d;
   localparam logic [7:0] ENH_KEY      = 8'hbf;
   localparam logic [7:0] ZERO_BYTE    = 8'h00;
   // Field positions
   localparam int FC_EN     = 0;
   localparam int FC_RXRST  = 1;
   localparam int FC_TXRST  = 2;
   localparam int LC_BREAK  = 6;
   localparam int LC_DIVSEL = 7;
   localparam int EF_UNLOCK = 4;
   localparam int EF_SPEC   = 5;
   localparam int EF_ARTS   = 6;
   localparam int EF_ACTS   = 7;
   // FIFO sizing and trigger levels
   localparam logic [6:0] DEPTH_ON  = 7'h40;
   localparam logic [6:0] DEPTH_OFF = 7'h01;
   localparam logic [6:0] LVL_8     = 7'h08;
   localparam logic [6:0] LVL_16    = 7'h10;
   localparam logic [6:0] LVL_32    = 7'h20;
   localparam logic [6:0] LVL_56    = 7'h38;
   localparam logic [6:0] LVL_60    = 7'h3c;
   // Flow-select codes
   localparam logic [1:0] FS_NONE   = 2'h0;
   localparam logic [1:0] FS_SECOND = 2'h1;
   localparam logic [1:0] FS_FIRST  = 2'h2;
   localparam logic [1:0] FS_BOTH   = 2'h3;

   // Received character from the receive shift register
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } ufc_char_t;
endpackage

// [bench/ufc_far.sv]
// Remote serial partner: sends received characters, takes transmit heads, drives CTS
module ufc_far
   import ufc_pkg::*;
(
   // Clock
   clk_sys,
   // Bench controls
   drain,
   stopTx,
   // Towards the block
   rxIn,
   txTake,
   txLineIn,
   ctsN,
   txValid,
   txByte,
   // Last character taken
   lastTx
);
   timeunit 1ns;
   timeprecision 1ps;
   input  wire logic       clk_sys;
   input  wire logic       drain;
   input  wire logic       stopTx;
   output      ufc_char_t  rxIn;
   output      logic       txTake;
   output      logic       txLineIn;
   output      logic       ctsN;
   input  wire logic       txValid;
   input  wire logic [7:0] txByte;
   output      logic [7:0] lastTx;

   // Idle values at time zero
   initial begin
      rxIn = '0;
      txTake = 1'b0;
      lastTx = 8'h00;
   end
   // Shifter line idles high; CTS follows the bench
   assign txLineIn = 1'b1;
   assign ctsN = stopTx;

   // Take the head only while it is offered
   always @(negedge clk_sys) begin
      txTake <= drain && txValid;
   end
   always @(posedge clk_sys) begin
      if (txTake && txValid)
         lastTx <= txByte;
   end

   // One received character; data inverted once the strobe drops
   task automatic send(input logic [7:0] b);
      @(negedge clk_sys);
      rxIn = {1'b1, b};
      @(negedge clk_sys);
      rxIn = {1'b0, ~b};
   endtask
endmodule

// [bench/tb_ufc_core.sv]
// Self-checking bench for the FIFO and flow-control block
module tb_ufc_core
   import ufc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic [2:0]  hostAddr = 3'h0;
   logic        hostWr = 1'b0;
   logic        hostRd = 1'b0;
   logic [7:0]  hostWrData = 8'h00;
   logic [7:0]  hostRdData;
   logic        specialFuncSel = 1'b0;
   ufc_char_t   rxIn;
   logic        txValid, txTake, txLineIn, txPin, rtsN, ctsN;
   logic        rxTrigger, txTrigger, sleepAllowed;
   logic [7:0]  txByte, lastTx;
   logic [15:0] divisor;
   logic [1:0]  txFlowSelect;
   logic        drain = 1'b0;
   logic        stopTx = 1'b0;
   logic [6:0]  lvl [4] = '{LVL_8, LVL_16, LVL_56, LVL_60};
   int          fails = 0;
   int          cmp_count = 0;

   ufc_core ufc_core_i (.clk_sys(clk_sys), .rst(rst), .hostAddr(hostAddr), .hostWr(hostWr),
      .hostRd(hostRd), .hostWrData(hostWrData), .hostRdData(hostRdData),
      .specialFuncSel(specialFuncSel), .rxIn(rxIn), .txValid(txValid), .txByte(txByte),
      .txTake(txTake), .txLineIn(txLineIn), .txPin(txPin), .rtsN(rtsN), .ctsN(ctsN),
      .rxTrigger(rxTrigger), .txTrigger(txTrigger), .divisor(divisor),
      .txFlowSelect(txFlowSelect), .sleepAllowed(sleepAllowed));
   ufc_far ufc_far_i (.clk_sys(clk_sys), .drain(drain), .stopTx(stopTx), .rxIn(rxIn),
      .txTake(txTake), .txLineIn(txLineIn), .ctsN(ctsN), .txValid(txValid),
      .txByte(txByte), .lastTx(lastTx));

   // Clock generator
   always #12.5 clk_sys = ~clk_sys;

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // Host write and read, one strobe cycle each
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      hostAddr = a;
      hostWrData = d;
      hostWr = 1'b1;
      @(negedge clk_sys);
      hostWr = 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      hostAddr = a;
      hostRd = 1'b1;
      @(negedge clk_sys);
      hostRd = 1'b0;
      chk(16'(hostRdData), 16'(exp));
   endtask
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Hang guard, far beyond the expected few hundred cycles
   initial begin
      #200000;
      fails++;
      summarize();
   end

   // Main sequence
   initial begin
      tick(12);
      rst = 1'b0;
      tick(3);
      chk(16'(rxTrigger), 16'h0);
      chk(16'(txTrigger), 16'h1);
      rd(OFS_LINE, LINE_RESET);
      rd(OFS_RES1, ZERO_BYTE);
      wr(OFS_DATA, 8'ha1);
      wr(OFS_DATA, 8'ha2);
      drain = 1'b1;
      tick(8);
      chk(16'(lastTx), 16'ha1);
      drain = 1'b0;
      // Transmit thresholds, locked then unlocked
      wr(OFS_FIFO, 8'h01);
      for (int i = 0; i < 9; i++) wr(OFS_DATA, 8'(i));
      wr(OFS_FIFO, 8'h31);
      tick(3);
      chk(16'(txTrigger), 16'h1);
      wr(OFS_LINE, ENH_KEY);
      wr(OFS_FIFO, 8'hd0);
      wr(OFS_LINE, ZERO_BYTE);
      wr(OFS_FIFO, 8'h31);
      tick(3);
      chk(16'(txTrigger), 16'h0);
      wr(OFS_FIFO, 8'h21);
      tick(3);
      chk(16'(txTrigger), 16'h1);
      wr(OFS_FIFO, 8'h35);
      tick(3);
      chk(16'(txValid), 16'h0);
      stopTx = 1'b1;
      drain = 1'b1;
      tick(4);
      wr(OFS_DATA, 8'h5a);
      tick(6);
      chk(16'(txValid), 16'h0);
      stopTx = 1'b0;
      tick(6);
      chk(16'(lastTx), 16'h5a);
      // Receive trigger levels with automatic RTS
      for (int c = 0; c < 4; c++) begin
         wr(OFS_FIFO, {2'(c), 6'h01});
         repeat (int'(lvl[c]) - 1) ufc_far_i.send(8'(c));
         tick(3);
         chk(16'(rxTrigger), 16'h0);
         chk(16'(rtsN), 16'h0);
         ufc_far_i.send(8'h55);
         tick(3);
         chk(16'(rxTrigger), 16'h1);
         chk(16'(rtsN), 16'h1);
         wr(OFS_FIFO, {2'(c), 6'h03});
         tick(3);
         chk(16'(rxTrigger), 16'h0);
      end
      // Special character, stored then used as stop
      rd(OFS_FIFO, 8'hc1);
      wr(OFS_LINE, ENH_KEY);
      wr(OFS_STOP2, 8'h7e);
      wr(OFS_RES2, 8'h11);
      wr(OFS_FIFO, 8'hf0);
      wr(OFS_LINE, ZERO_BYTE);
      ufc_far_i.send(8'h7e);
      tick(3);
      rd(OFS_FIFO, 8'hd0);
      rd(OFS_FIFO, 8'hc1);
      rd(OFS_DATA, 8'h7e);
      wr(OFS_LINE, ENH_KEY);
      wr(OFS_FIFO, 8'hf1);
      wr(OFS_LINE, ZERO_BYTE);
      ufc_far_i.send(8'h7e);
      tick(3);
      rd(OFS_FIFO, 8'hd0);
      wr(OFS_DATA, 8'h33);
      tick(6);
      chk(16'(lastTx), 16'h5a);
      ufc_far_i.send(8'h11);
      tick(8);
      chk(16'(lastTx), 16'h33);
      // Divisor bank, enhanced bank, break
      wr(OFS_LINE, 8'h80);
      wr(OFS_DIV_LOW, 8'h34);
      wr(OFS_DIV_HIGH, 8'h12);
      tick(2);
      chk(divisor, 16'h1234);
      rd(OFS_DIV_HIGH, 8'h12);
      wr(OFS_LINE, ENH_KEY);
      rd(OFS_DIV_HIGH, ZERO_BYTE);
      wr(OFS_FIFO, 8'hfd);
      rd(OFS_FIFO, 8'hfd);
      chk(16'(txFlowSelect), 16'h3);
      chk(16'(sleepAllowed), 16'h1);
      specialFuncSel = 1'b1;
      rd(OFS_FIFO, ZERO_BYTE);
      specialFuncSel = 1'b0;
      wr(OFS_LINE, 8'h40);
      tick(2);
      chk(16'(txPin), 16'h0);
      wr(OFS_LINE, ZERO_BYTE);
      tick(2);
      chk(16'(txPin), 16'h1);
      // Either-character flow control: first stop, second resume
      wr(OFS_LINE, ENH_KEY);
      wr(OFS_RES1, 8'h21);
      wr(OFS_STOP1, 8'h13);
      wr(OFS_FIFO, 8'h0b);
      wr(OFS_LINE, ZERO_BYTE);
      ufc_far_i.send(8'h13);
      wr(OFS_DATA, 8'h44);
      tick(6);
      chk(16'(lastTx), 16'h33);
      ufc_far_i.send(8'h11);
      tick(8);
      chk(16'(lastTx), 16'h44);
      // Two-character flow control: a lone second stop is plain data
      wr(OFS_LINE, ENH_KEY);
      wr(OFS_FIFO, 8'h03);
      wr(OFS_LINE, ZERO_BYTE);
      ufc_far_i.send(8'h7e);
      tick(2);
      rd(OFS_DATA, 8'h7e);
      ufc_far_i.send(8'h13);
      ufc_far_i.send(8'h7e);
      wr(OFS_DATA, 8'h55);
      tick(6);
      chk(16'(lastTx), 16'h44);
      rd(OFS_FIFO, 8'hd0);
      ufc_far_i.send(8'h21);
      ufc_far_i.send(8'h11);
      tick(8);
      chk(16'(lastTx), 16'h55);
      rd(OFS_FIFO, 8'hc1);
      summarize();
   end
endmodule
